// [sfc_cycle_engine.sv]
// Programmed-cycle engine: register file on i_clk, serial shifter on i_link_clk.
// Assumes i_link_clk runs free; i_miso is driven in step with o_sck.
`timescale 1ns/1ps
module sfc_cycle_engine (
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    input  wire logic                 i_link_clk,
    input  wire sfc_pkg::sfc_req_type i_req,
    output logic [63:0]               o_rdata,
    input  wire logic                 i_strap_flash,
    input  wire logic                 i_miso,
    output logic                      o_sck,
    output logic                      o_mosi,
    output logic                      o_chip_select_zero_n,
    output logic                      o_chip_select_one_n,
    output logic                      o_cs0_is_flash,
    output logic                      o_system_mgmt_request
);
    import sfc_pkg::*;

    function automatic logic [7:0] pick_byte(input logic [127:0] v, input logic [3:0] i);
        pick_byte = v[{i, 3'b000} +: 8];
    endfunction

    // Core-domain registers
    logic        lock;
    logic        blocked;
    logic        done;
    logic        busy;
    logic        boot_pend;
    logic        boot_run;
    logic [15:0] ctl;
    logic [23:0] address;
    logic [63:0] data0;
    logic [63:0] data1;
    logic [15:0] bottom;
    logic [15:0] prefix;
    logic [15:0] opcode_type_reg;
    logic [63:0] menu;
    logic [31:0] range0;
    sfc_job_type job;
    logic        start_tog;
    logic [2:0]  dsync;
    logic        done_seen;
    logic [2:0]  ssync;
    logic        smi;

    // Link-domain registers
    logic [1:0]   lrst_q;
    logic [2:0]   gsync;
    logic         go_seen;
    sfc_link_type lstate;
    logic         half;
    logic         sck;
    logic         samp;
    logic [2:0]   bitcnt;
    logic [3:0]   bytecnt;
    logic [1:0]   aidx;
    logic [7:0]   shreg;
    logic [127:0] ldata;
    logic         done_tog;
    logic         cs0_n;
    logic         cs1_n;

    // Register port decode
    wire        wr       = i_req.write;
    wire [6:0]  ra       = i_req.addr;
    wire [15:0] cw       = i_req.wdata[15:0];
    wire        wr_stat  = wr && ra == OFS_STATUS;
    wire        wr_ctl   = wr && ra == OFS_CONTROL;
    wire        wr_addr  = wr && ra == OFS_ADDRESS;
    wire        wr_d0    = wr && ra == OFS_DATA0;
    wire        wr_d1    = wr && ra == OFS_DATA1;
    wire        wr_cfg   = wr && !lock;
    wire        wr_cycle = wr_ctl || wr_addr || wr_d0 || wr_d1;

    // Job decode from the control word being written
    wire [2:0]  optr     = cw[CT_OPPTR +: 3];
    wire [1:0]  otype    = opcode_type_reg[{optr, 1'b0} +: 2];
    wire [1:0]  port     = cw[CT_PORT +: 2];
    wire        go_req   = wr_ctl && cw[CT_GO] && !busy;
    wire        port_bad = port == PORT_RSVD;
    wire        prot_hit = otype[1] && bottom != 16'h0000 && address < {bottom, 8'h00};
    wire        refuse   = go_req && (port_bad || prot_hit);
    wire        launch   = go_req && !refuse;
    wire        boot_go  = boot_pend && !busy && !go_req;

    sfc_job_type prog_job;
    sfc_job_type boot_job;
    assign prog_job.prefix     = cw[CT_PREPTR] ? prefix[15:8] : prefix[7:0];
    assign prog_job.opcode     = menu[{optr, 3'b000} +: 8];
    assign prog_job.addr       = address;
    assign prog_job.use_prefix = cw[CT_ATOM];
    assign prog_job.use_addr   = otype[1] && !cw[CT_DATOM];
    assign prog_job.use_data   = cw[CT_DATA];
    assign prog_job.is_read    = !otype[0];
    assign prog_job.count      = cw[CT_COUNT +: 4];
    assign prog_job.cs_one     = port != 2'h0;
    assign boot_job = '{prefix: 8'h00, opcode: BOOT_OPCODE, addr: 24'h000000,
                        use_prefix: 1'b0, use_addr: 1'b0, use_data: 1'b1,
                        is_read: 1'b1, count: 4'h0, cs_one: 1'b0};

    // Completion seen once the last two synchroniser stages agree
    wire done_ev   = dsync[2] == dsync[1] && dsync[2] != done_seen;
    wire clr_done  = wr_stat && i_req.wdata[ST_DONE];
    wire clr_block = wr_stat && i_req.wdata[ST_BLOCKED];
    wire set_done  = done_ev && !boot_run;
    wire set_block = refuse || (wr_cycle && busy);
    wire fifo_empty = !(busy && job.use_data);
    wire [15:0] status = {lock, 11'h000, blocked, done, fifo_empty, busy};

    wire [63:0] rd_val =
        ra == OFS_STATUS  ? {48'h0, status} :
        ra == OFS_CONTROL ? {48'h0, ctl} :
        ra == OFS_ADDRESS ? {40'h0, address} :
        ra == OFS_DATA0   ? data0 :
        ra == OFS_DATA1   ? data1 :
        ra == OFS_BOTTOM  ? {40'h0, bottom, 8'h00} :
        ra == OFS_PREFIX  ? {48'h0, prefix} :
        ra == OFS_OPCODE_TYPE_REG  ? {48'h0, opcode_type_reg} :
        ra == OFS_MENU    ? menu :
        ra == OFS_RANGE0  ? {32'h0, range0} : 64'h0;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lock    <= 1'b0;
            blocked <= 1'b0;
            done    <= 1'b0;
            smi     <= 1'b0;
            o_rdata <= 64'h0;
        end else begin
            lock    <= lock || (wr_stat && i_req.wdata[ST_LOCK]);
            blocked <= set_block || (blocked && !clr_block);
            done    <= set_done || (done && !clr_done);
            smi     <= ctl[CT_SMI] && done;
            if (i_req.read) begin
                o_rdata <= rd_val;
            end
        end
    end

    // Control and address are frozen while busy so the link can read them quietly; the rest here only by lock
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctl     <= RST_CONTROL;
            address <= 24'h000000;
            bottom  <= 16'h0000;
            prefix  <= RST_PREFIX;
            opcode_type_reg  <= 16'h0000;
            menu    <= 64'h0;
            range0  <= 32'h0;
        end else begin
            if (wr_ctl && !busy) begin
                ctl <= {cw[15:2], 1'b0, cw[0]};
            end
            if (wr_addr && !busy) begin
                address <= i_req.wdata[23:0];
            end
            if (wr_cfg && ra == OFS_BOTTOM) begin
                bottom <= i_req.wdata[23:8];
            end
            if (wr_cfg && ra == OFS_PREFIX) begin
                prefix <= cw;
            end
            if (wr_cfg && ra == OFS_OPCODE_TYPE_REG) begin
                opcode_type_reg <= cw;
            end
            if (wr_cfg && ra == OFS_MENU) begin
                menu <= i_req.wdata;
            end
            if (wr_cfg && ra == OFS_RANGE0) begin
                range0 <= i_req.wdata[31:0] & RANGE_MASK;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            data0 <= 64'h0;
            data1 <= 64'h0;
        end else if (done_ev && job.use_data && job.is_read) begin
            data0 <= ldata[63:0];
            data1 <= ldata[127:64];
        end else if (!busy) begin
            if (wr_d0) begin
                data0 <= i_req.wdata;
            end
            if (wr_d1) begin
                data1 <= i_req.wdata;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy      <= 1'b0;
            boot_pend <= 1'b1;
            boot_run  <= 1'b0;
            job       <= '0;
            start_tog <= 1'b0;
        end else if (launch || boot_go) begin
            busy      <= 1'b1;
            job       <= launch ? prog_job : boot_job;
            boot_pend <= boot_pend && launch;
            boot_run  <= !launch;
            start_tog <= !start_tog;
        end else if (done_ev) begin
            busy     <= 1'b0;
            boot_run <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            dsync     <= 3'b000;
            done_seen <= 1'b0;
            ssync     <= 3'b000;
            o_cs0_is_flash <= 1'b0;
        end else begin
            dsync <= {dsync[1:0], done_tog};
            ssync <= {ssync[1:0], i_strap_flash};
            if (done_ev) begin
                done_seen <= dsync[2];
            end
            if (ssync[2] == ssync[1]) begin
                o_cs0_is_flash <= ssync[2];
            end
        end
    end

    assign o_system_mgmt_request = smi;

    // Link domain
    wire       lrst_n   = lrst_q[1];
    wire       go_ev    = gsync[2] == gsync[1] && gsync[2] != go_seen;
    wire [7:0] rx_byte  = {shreg[6:0], samp};
    wire       byte_end = half && bitcnt == 3'h7;
    wire [7:0] addr_nxt = aidx == 2'h0 ? job.addr[15:8] : job.addr[7:0];
    wire [3:0] next_cnt = bytecnt + 4'h1;

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lrst_q <= 2'b00;
        end else begin
            lrst_q <= {lrst_q[0], 1'b1};
        end
    end

    always_ff @(posedge i_link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            gsync   <= 3'b000;
            go_seen <= 1'b0;
        end else begin
            gsync <= {gsync[1:0], start_tog};
            if (go_ev) begin
                go_seen <= gsync[2];
            end
        end
    end

    // Two link clocks per bit: low half drives, rising edge samples
    always_ff @(posedge i_link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            lstate   <= LK_IDLE;
            half     <= 1'b0;
            sck      <= 1'b0;
            samp     <= 1'b0;
            bitcnt   <= 3'h0;
            bytecnt  <= 4'h0;
            aidx     <= 2'h0;
            shreg    <= 8'h00;
            ldata    <= 128'h0;
            done_tog <= 1'b0;
            cs0_n    <= 1'b1;
            cs1_n    <= 1'b1;
        end else begin
            unique case (lstate)
                LK_IDLE: if (go_ev) begin
                    cs0_n  <= job.cs_one;
                    cs1_n  <= !job.cs_one;
                    ldata  <= {data1, data0};
                    half   <= 1'b0;
                    bitcnt <= 3'h0;
                    shreg  <= job.use_prefix ? job.prefix : job.opcode;
                    lstate <= job.use_prefix ? LK_PREFIX : LK_OPCODE;
                end
                LK_GAP: begin
                    cs0_n  <= job.cs_one;
                    cs1_n  <= !job.cs_one;
                    shreg  <= job.opcode;
                    lstate <= LK_OPCODE;
                end
                LK_PREFIX, LK_OPCODE, LK_ADDR, LK_DATA: begin
                    half <= !half;
                    sck  <= !half;
                    if (!half) begin
                        samp <= i_miso;
                    end else begin
                        bitcnt <= bitcnt + 3'h1;
                        shreg  <= rx_byte;
                    end
                    if (byte_end) begin
                        if (lstate == LK_PREFIX) begin
                            cs0_n  <= 1'b1;
                            cs1_n  <= 1'b1;
                            lstate <= LK_GAP;
                        end else if (lstate == LK_OPCODE && job.use_addr) begin
                            shreg  <= job.addr[23:16];
                            aidx   <= 2'h0;
                            lstate <= LK_ADDR;
                        end else if (lstate == LK_ADDR && aidx != 2'h2) begin
                            shreg <= addr_nxt;
                            aidx  <= aidx + 2'h1;
                        end else if (lstate == LK_DATA && bytecnt != job.count) begin
                            if (job.is_read) begin
                                ldata[{bytecnt, 3'b000} +: 8] <= rx_byte;
                            end
                            bytecnt <= next_cnt;
                            shreg   <= pick_byte(ldata, next_cnt);
                        end else if (lstate != LK_DATA && job.use_data) begin
                            bytecnt <= 4'h0;
                            shreg   <= pick_byte(ldata, 4'h0);
                            lstate  <= LK_DATA;
                        end else begin
                            if (lstate == LK_DATA && job.is_read) begin
                                ldata[{bytecnt, 3'b000} +: 8] <= rx_byte;
                            end
                            cs0_n    <= 1'b1;
                            cs1_n    <= 1'b1;
                            done_tog <= !done_tog;
                            lstate   <= LK_IDLE;
                        end
                    end
                end
                default: lstate <= LK_IDLE;
            endcase
        end
    end

    assign o_sck  = sck;
    assign o_mosi = shreg[7];
    assign o_chip_select_zero_n = cs0_n;
    assign o_chip_select_one_n  = cs1_n;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    a_done_sticky: assert property (done && !clr_done |=> done)
        else $error("cycle done dropped without a clear");
    a_boot_no_done: assert property (boot_run && done_ev && !done |=> !done)
        else $error("boot status read set cycle done");
    a_empty_idle: assert property (!busy |-> status[1])
        else $error("fifo empty low while idle");
    a_go_busy: assert property (launch |=> busy [*3])
        else $error("go did not hold cycle in progress");
    a_smi_follow: assert property (ctl[CT_SMI] && done |=> o_system_mgmt_request)
        else $error("management request missing");
    a_port_rsvd: assert property (go_req && port_bad |=> !busy && blocked)
        else $error("reserved target was run");
    a_go_ignored: assert property (wr_ctl && busy |=> $stable(ctl) && blocked)
        else $error("control changed during a cycle");
    a_go_reads0: assert property (ctl[CT_GO] == 1'b0)
        else $error("go bit read back as one");
    a_bottom_guard: assert property (go_req && prot_hit |=> !busy && blocked)
        else $error("cycle below bottom limit ran");
    a_lock_menu: assert property (lock && wr && ra == OFS_MENU |=> $stable(menu))
        else $error("menu written while locked");
    a_lock_keep: assert property ($rose(lock) |=> lock [*8])
        else $error("lock bit cleared");
    a_idle_desel: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
        lstate == LK_IDLE |-> cs0_n && cs1_n)
        else $error("chip select active while idle");
endmodule

// [sfc_pkg.sv]
// Constants, register map and carrier types of the serial flash cycle engine.
// Assumes a byte-addressed register port and a separate link clock.
package sfc_pkg;
    localparam logic [6:0]  OFS_STATUS  = 7'h00;
    localparam logic [6:0]  OFS_CONTROL = 7'h02;
    localparam logic [6:0]  OFS_ADDRESS = 7'h04;
    localparam logic [6:0]  OFS_DATA0   = 7'h08;
    localparam logic [6:0]  OFS_DATA1   = 7'h10;
    localparam logic [6:0]  OFS_BOTTOM  = 7'h50;
    localparam logic [6:0]  OFS_PREFIX  = 7'h54;
    localparam logic [6:0]  OFS_OPCODE_TYPE_REG  = 7'h56;
    localparam logic [6:0]  OFS_MENU    = 7'h58;
    localparam logic [6:0]  OFS_RANGE0  = 7'h60;

    localparam logic [15:0] RST_CONTROL = 16'h4004;
    localparam logic [15:0] RST_PREFIX  = 16'h0004;
    localparam logic [31:0] RANGE_MASK  = 32'h80FFFFFF;
    localparam logic [7:0]  BOOT_OPCODE = 8'h05;
    localparam logic [1:0]  PORT_RSVD   = 2'h3;

    localparam int ST_LOCK    = 15;
    localparam int ST_BLOCKED = 3;
    localparam int ST_DONE    = 2;
    localparam int CT_SMI     = 15;
    localparam int CT_DATA    = 14;
    localparam int CT_PORT    = 12;
    localparam int CT_COUNT   = 8;
    localparam int CT_DATOM   = 7;
    localparam int CT_OPPTR   = 4;
    localparam int CT_PREPTR  = 3;
    localparam int CT_ATOM    = 2;
    localparam int CT_GO      = 1;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [6:0]  addr;
        logic [63:0] wdata;
    } sfc_req_type;

    typedef struct packed {
        logic [7:0]  prefix;
        logic [7:0]  opcode;
        logic [23:0] addr;
        logic        use_prefix;
        logic        use_addr;
        logic        use_data;
        logic        is_read;
        logic [3:0]  count;
        logic        cs_one;
    } sfc_job_type;

    typedef enum logic [2:0] {
        LK_IDLE   = 3'b000,
        LK_PREFIX = 3'b001,
        LK_GAP    = 3'b010,
        LK_OPCODE = 3'b011,
        LK_ADDR   = 3'b100,
        LK_DATA   = 3'b101
    } sfc_link_type;
endpackage

// [sfc_flash_model.sv]
// Behavioural serial flash at the far end of the link: logs every byte on its data-in line (i_mosi).
// Assumes mode 0 framing and one combined active-low select from the two chip selects.
`timescale 1ns/1ps
module sfc_flash_model (
    input  wire logic i_sck,
    input  wire logic i_cs_n,
    input  wire logic i_mosi,
    output logic      o_miso
);
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    int         bit_n;
    int         byte_n;
    logic [7:0] got[$];

    initial o_miso = 1'b0;
    // Byte k of each frame answers C3h xor k, so every captured byte is traceable
    always @(negedge i_cs_n) begin
        bit_n = 0;
        byte_n = 0;
        tx_sh = 8'hC3;
        o_miso = tx_sh[7];
    end
    // Released line shows the inverse, never a stale copy
    always @(posedge i_cs_n) o_miso = ~o_miso;
    always @(posedge i_sck) if (!i_cs_n) begin
        rx_sh = {rx_sh[6:0], i_mosi};
        bit_n++;
        tx_sh = {tx_sh[6:0], 1'b0};
        if (bit_n == 8) begin
            got.push_back(rx_sh);
            bit_n = 0;
            byte_n++;
            tx_sh = 8'hC3 ^ 8'(byte_n);
        end
    end
    always @(negedge i_sck) if (!i_cs_n) o_miso = tx_sh[7];
endmodule

// [serial_flash_cycle_engine_tb_top.sv]
// Self-checking bench of the serial flash cycle engine: register tasks, flash model on the link.
// Assumes the flash model answers byte k of each frame with C3h xor k.
`timescale 1ns/1ps
module serial_flash_cycle_engine_tb_top;
    import sfc_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rstn = 1'b0;
    logic        i_link_clk = 1'b0;
    sfc_req_type req = '0;
    logic [63:0] rdata;
    logic        sck, mosi, miso, cs0_n, cs1_n, cs0_flash, smi;
    logic        strap = 1'b1;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          cs1_cnt = 0;
    logic [63:0] d;
    logic [7:0]  exp_q[$];

    always #5 i_clk = ~i_clk;
    always #24 i_link_clk = ~i_link_clk;
    always @(negedge cs1_n) cs1_cnt++;

    sfc_cycle_engine uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_link_clk(i_link_clk), .i_req(req), .o_rdata(rdata),
        .i_strap_flash(strap), .i_miso(miso), .o_sck(sck), .o_mosi(mosi), .o_chip_select_zero_n(cs0_n),
        .o_chip_select_one_n(cs1_n), .o_cs0_is_flash(cs0_flash), .o_system_mgmt_request(smi));
    sfc_flash_model fm (.i_sck(sck), .i_cs_n(cs0_n & cs1_n), .i_mosi(mosi), .o_miso(miso));

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [63:0] v);
        @(posedge i_clk);
        req.write <= 1'b1;
        req.addr <= a;
        req.wdata <= v;
        @(posedge i_clk);
        req.write <= 1'b0;
    endtask

    task automatic rd(input logic [6:0] a);
        @(posedge i_clk);
        req.read <= 1'b1;
        req.addr <= a;
        @(posedge i_clk);
        req.read <= 1'b0;
        #1 d = rdata;
    endtask

    // Poll progress before the next command; bounded so a stuck flag cannot hang the run
    task automatic wait_idle();
        d = 64'h1;
        for (int i = 0; i < 1000 && d[0] !== 1'b0; i++) rd(OFS_STATUS);
        chk("busy", d[0], 1'b0);
    endtask

    task automatic run(input logic [15:0] ctl);
        wr(OFS_STATUS, 64'hC);
        fm.got.delete();
        wr(OFS_CONTROL, {48'h0, ctl});
        wait_idle();
        chk("frame length", 64'(fm.got.size()), 64'(exp_q.size()));
        foreach (exp_q[i]) chk("frame byte", fm.got[i], exp_q[i]);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 50000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        wait_idle();
        chk("boot opcode", fm.got[0], BOOT_OPCODE);
        rd(OFS_DATA0);
        chk("boot status", d, 64'hC2);
        rd(OFS_STATUS);
        chk("status after boot", d[15:0], 16'h0002);
        rd(OFS_CONTROL);
        chk("control reset", d[15:0], RST_CONTROL);
        rd(OFS_PREFIX);
        chk("prefix reset", d[15:0], RST_PREFIX);
        chk("strap", cs0_flash, 1'b1);
        $display("test reset done");

        wr(OFS_MENU, 64'h1716151413121110);
        wr(OFS_OPCODE_TYPE_REG, 64'h01E0);
        wr(OFS_PREFIX, 64'hA550);
        wr(OFS_ADDRESS, 64'h123456);
        // Opcode 2, addressed read, three bytes, management request enabled
        exp_q = '{8'h12, 8'h12, 8'h34, 8'h56, 8'hC2, 8'h00, 8'h00};
        run(16'hC222);
        rd(OFS_DATA0);
        chk("read capture", d, 64'hC5C6C7);
        rd(OFS_STATUS);
        chk("done set", d[15:0], 16'h0006);
        chk("mgmt request", smi, 1'b1);
        rd(OFS_CONTROL);
        chk("go reads zero", d[15:0], 16'hC220);
        wr(OFS_STATUS, 64'h4);
        rd(OFS_STATUS);
        chk("done cleared", d[15:0], 16'h0002);
        chk("mgmt dropped", smi, 1'b0);
        $display("test read cycle done");

        // Atomic write: high prefix, opcode 3, ten bytes spilling into the second buffer
        wr(OFS_DATA0, 64'h8877665544332211);
        wr(OFS_DATA1, 64'hBBAA);
        exp_q = '{8'hA5, 8'h13, 8'h12, 8'h34, 8'h56, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88,
                  8'hAA, 8'hBB};
        run(16'h493E);
        rd(OFS_DATA1);
        chk("write keeps buffer", d, 64'hBBAA);
        chk("chip select zero used", 64'(cs1_cnt), 64'h0);
        $display("test atomic write done");

        // Target codes 01, 10 and reserved 11 with no data phase
        for (int p = 1; p < 4; p++) begin
            if (p == 3) begin
                exp_q = {};
            end else begin
                exp_q = '{8'h14};
            end
            run(16'h0042 | 16'(p << 12));
        end
        chk("chip select one hits", 64'(cs1_cnt), 64'h2);
        rd(OFS_STATUS);
        chk("reserved blocked", d[15:0], 16'h000A);
        $display("test targets done");

        wr(OFS_BOTTOM, 64'h2000);
        wr(OFS_ADDRESS, 64'h1FFF);
        exp_q = {};
        run(16'h4022);
        rd(OFS_STATUS);
        chk("below bottom blocked", d[15:0], 16'h000A);
        wr(OFS_ADDRESS, 64'h2000);
        exp_q = '{8'h12, 8'h00, 8'h20, 8'h00, 8'h11};
        run(16'h4022);
        exp_q = '{8'h12, 8'hC7};
        run(16'h40A2);
        rd(OFS_STATUS);
        chk("done without request", d[15:0], 16'h0006);
        chk("mgmt disabled", smi, 1'b0);
        $display("test bottom limit done");

        wr(OFS_STATUS, 64'h8000);
        wr(OFS_PREFIX, 64'h0);
        rd(OFS_PREFIX);
        chk("locked prefix", d[15:0], 16'hA550);
        wr(OFS_STATUS, 64'h0);
        rd(OFS_STATUS);
        chk("lock stays", d[15], 1'b1);
        $display("test lock done");

        // Strap low must reach the target flag through the filter
        @(posedge i_clk);
        strap <= 1'b0;
        repeat (6) @(posedge i_clk);
        #1 chk("strap low", cs0_flash, 1'b0);
        $display("test strap done");

        // Second reset mid-run: lock falls and the boot status read runs again
        @(posedge i_clk);
        i_rstn <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        wait_idle();
        rd(OFS_STATUS);
        chk("lock cleared by reset", d[15:0], 16'h0002);
        rd(OFS_DATA0);
        chk("boot status again", d, 64'hC2);
        rd(OFS_PREFIX);
        chk("prefix after reset", d[15:0], RST_PREFIX);
        $display("test second reset done");
        summarize();
    end
endmodule
